// [rtl/cpu_clock_power_pkg.sv]
package cpu_clock_power_pkg;
  // Register port addresses
  localparam logic [15:0] ADDR_CPU_CLOCK_CONTROL = 16'h1072;
  localparam logic [15:0] ADDR_COPROC_BUS_POWER = 16'h1872;
  // Clock control fields
  localparam int CCR_HOLD_STOP_BIT = 0;
  localparam int CCR_HALT_HOLD_STOP_BIT = 1;
  localparam int CCR_STRETCH_LO = 4;
  localparam int CCR_STRETCH_HI = 7;
  localparam int CCR_DIV_LO = 12;
  localparam int CCR_DIV_HI = 14;
  localparam logic [15:0] CCR_RESET = 16'h1000;
  localparam logic [15:0] CCR_WRITE_MASK = 16'hfff3;
  // Bus timing and power fields
  localparam int PWR_CPU_PD_BIT = 14;
  localparam int PWR_FULL_PD_BIT = 13;
  localparam logic [15:0] PWR_RESET = 16'h00c2;
  localparam logic [15:0] PWR_WRITE_MASK = 16'h6fff;
  // Mux select codes
  localparam logic [2:0] SEL_SPEED = 3'h0;
  localparam logic [2:0] SEL_POWER_GOOD = 3'h1;
  localparam logic [2:0] SEL_LOCAL_REQ = 3'h2;
  localparam logic [2:0] SEL_STRAP = 3'h4;
  localparam logic [2:0] SEL_STEP = 3'h1;
  // Divisor codes
  localparam logic [2:0] DIV_INPUT = 3'h0;
  localparam logic [2:0] DIV_BY1 = 3'h1;
  localparam logic [2:0] DIV_BY2 = 3'h2;
  localparam logic [2:0] DIV_BY4_25 = 3'h3;
  localparam logic [2:0] DIV_BY4_75 = 3'h4;
  localparam logic [2:0] DIV_BY8_12 = 3'h5;
  localparam logic [2:0] DIV_BY8_88 = 3'h6;
  localparam logic [3:0] STRETCH_NONE = 4'h0;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRETCH_UNIT_NS = 1000;
  localparam int CYCLES_PER_US = (STRETCH_UNIT_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int STRETCH_CW = 11;
  localparam int STRAP_SETTLE_NS = 200;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CPU_RESET_NS = 1000;
  localparam int CPU_RESET_CYCLES = (CPU_RESET_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    CLK_RUN = 2'b01,
    CLK_STOPPED = 2'b10
  } clk_state_t;

  typedef enum logic [4:0] {
    PD_IDLE = 5'b00001,
    PD_CPU_OFF = 5'b00010,
    PD_FULL_OFF = 5'b00100,
    PD_WAKE = 5'b01000,
    PD_RESET = 5'b10000
  } pd_state_t;
endpackage : cpu_clock_power_pkg

// [rtl/pin_sync.sv]
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Pins in, synchronised out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= pin;
      sync <= meta_q;
    end
  end
endmodule : pin_sync

// [rtl/cpu_clock_power_mux_ctrl.sv]
// Summary of operation
// - Stretch field adds 0 to 15 us hold
// - Speed switch asserted forces stretch to zero
// - Switch released restores programmed stretch value
// - Halt-hold stop bit stops clock on both
// - Interrupt restarts clock; halt-hold bit stays set
// - Hold stop bit stops clock at hold
// - Interrupt restarts clock and clears hold bit
// - Refresh continues while processor clock stopped
// - Reset drives mux select to 100
// - Decoder enable gates acknowledge and bus reset
// - Select held stable during DMA transfer
// - Strap at 100 sets clock pin direction
// - Muxed inputs sampled each double bus rising edge, except during the strap window, DMA acknowledge and full power-down
// - Boot ROM width captured after reset
// - Power input codes: speed, power good, request
// - Power-down bit rising starts at halt
// - Power-down masks inputs, sets out5, tristates
// - Wake clears out5; power good resets processor
// - Full power-down at halt: tristate, out7
// - Full power-down gates sleep refresh tick
// - Wake clears out7, resets until power good
// - Full power-down bit cleared only by software
// - Stopped clock held in phase two
// - Divisor default from clock direction strap
module cpu_clock_power_mux_ctrl (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // Processor status, same clock
  input wire logic cpu_halt,
  input wire logic cpu_hold,
  input wire logic irq_unmasked,
  input wire logic nmi,
  input wire logic power_ctrl_irq,
  // Refresh and DMA, same clock
  input wire logic refresh_busy,
  input wire logic refresh_done,
  input wire logic refresh_req,
  input wire logic cbr_refresh_en,
  input wire logic dma_ack_active,
  input wire logic [2:0] dma_channel,
  // Pins from external muxes
  input wire logic bus_clock_double,
  input wire logic muxed_request_in,
  input wire logic muxed_irq_in_a,
  input wire logic muxed_irq_in_b,
  input wire logic muxed_power_in,
  input wire logic sleep_refresh_tick,
  // Mux and decoder control
  output logic [2:0] mux_select,
  output logic ack_decoder_enable,
  // Scanned inputs
  output logic [7:0] request_vector,
  output logic [7:0] irq_a_vector,
  output logic [7:0] irq_b_vector,
  output logic [7:0] power_in_vector,
  output logic boot_rom_width,
  output logic speed_switch_input,
  // Processor side
  output logic processor_clock,
  output logic processor_clock_oe_n,
  output logic hold_request,
  output logic cpu_reset_out,
  output logic cpu_outputs_oe_n,
  output logic cpu_inputs_masked,
  output logic cpu_pullup_en,
  // Power control and refresh
  output logic power_ctrl_out5,
  output logic power_ctrl_out7,
  output logic refresh_out
);
  import cpu_clock_power_pkg::*;

  logic [15:0] ccr_q;
  logic [15:0] pwr_q;
  logic [2:0] sel_q;
  logic scan_en_q;
  logic [CNT_W-1:0] strap_cnt_q;
  logic clk_dir_in_q;
  logic bcd_prev_q;
  logic [STRETCH_CW-1:0] stretch_cnt_q;
  logic [3:0] div_cnt_q;
  logic cpu_clk_q;
  logic bus_reset_req_q;
  logic pd_armed_q;
  logic wake_full_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [5:0] pin_s;
  logic bcd_s;
  logic req_s;
  logic irqa_s;
  logic irqb_s;
  logic pwr_s;
  logic tick_s;
  logic bcd_edge;
  logic halt_m;
  logic hold_m;
  logic wake_evt;
  logic wr_ccr;
  logic wr_pwr;
  logic full_off;
  logic [3:0] stretch_eff;
  logic [2:0] div_sel;
  logic [3:0] div_period;
  logic [3:0] div_high;
  logic power_good;
  clk_state_t clk_state_q;
  pd_state_t pd_state_q;

  pin_sync #(.W(6)) u_pin_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin({bus_clock_double, muxed_request_in, muxed_irq_in_a,
      muxed_irq_in_b, muxed_power_in, sleep_refresh_tick}),
    .sync(pin_s)
  );

  assign {bcd_s, req_s, irqa_s, irqb_s, pwr_s, tick_s} = pin_s;
  assign bcd_edge = bcd_s & ~bcd_prev_q;
  assign full_off = (pd_state_q == PD_FULL_OFF);
  // Processor side is passive while masked
  assign halt_m = cpu_halt & ~cpu_inputs_masked;
  assign hold_m = cpu_hold & ~cpu_inputs_masked;
  assign wake_evt = irq_unmasked | nmi;
  assign wr_ccr = io_wr && (io_addr == ADDR_CPU_CLOCK_CONTROL);
  assign wr_pwr = io_wr && (io_addr == ADDR_COPROC_BUS_POWER);
  assign speed_switch_input = power_in_vector[SEL_SPEED];
  assign power_good = power_in_vector[SEL_POWER_GOOD];
  assign stretch_eff = speed_switch_input ? STRETCH_NONE
    : ccr_q[CCR_STRETCH_HI:CCR_STRETCH_LO];
  assign div_sel = ccr_q[CCR_DIV_HI:CCR_DIV_LO];

  // Register writes; reserved bits never store
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ccr_q <= CCR_RESET;
    end
    else if (clk_en)
    begin
      if (!scan_en_q && strap_cnt_q == CNT_W'(STRAP_SETTLE_CYCLES))
      begin
        ccr_q[CCR_DIV_HI:CCR_DIV_LO] <= req_s ? DIV_INPUT : DIV_BY1;
      end
      else if (wr_ccr)
      begin
        ccr_q <= io_wdata & CCR_WRITE_MASK;
      end
      else if (clk_state_q == CLK_STOPPED && wake_evt)
      begin
        ccr_q[CCR_HOLD_STOP_BIT] <= 1'b0;
      end
    end
  end

  // Full power-down bit is only ever changed by a write
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_q <= PWR_RESET;
    end
    else if (clk_en && wr_pwr)
    begin
      pwr_q <= io_wdata & PWR_WRITE_MASK;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      io_rdata <= '0;
    end
    else if (clk_en && io_rd)
    begin
      if (io_addr == ADDR_CPU_CLOCK_CONTROL)
      begin
        io_rdata <= ccr_q;
      end
      else if (io_addr == ADDR_COPROC_BUS_POWER)
      begin
        io_rdata <= pwr_q;
      end
      else
      begin
        io_rdata <= '0;
      end
    end
  end

  // Strap window after reset, then free scan
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scan_en_q <= 1'b0;
      strap_cnt_q <= '0;
      clk_dir_in_q <= 1'b0;
      boot_rom_width <= 1'b0;
    end
    else if (clk_en && !scan_en_q)
    begin
      if (strap_cnt_q == CNT_W'(STRAP_SETTLE_CYCLES))
      begin
        scan_en_q <= 1'b1;
        clk_dir_in_q <= req_s;
        boot_rom_width <= irqa_s;
      end
      else
      begin
        strap_cnt_q <= strap_cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bcd_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      bcd_prev_q <= bcd_s;
    end
  end

  // Select scan; a DMA channel owns the select while acknowledged
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_q <= SEL_STRAP;
      request_vector <= '0;
      irq_a_vector <= '0;
      irq_b_vector <= '0;
      power_in_vector <= '0;
    end
    else if (clk_en && scan_en_q && !full_off)
    begin
      if (dma_ack_active)
      begin
        sel_q <= dma_channel;
      end
      else if (bcd_edge)
      begin
        request_vector[sel_q] <= req_s;
        irq_a_vector[sel_q] <= irqa_s;
        irq_b_vector[sel_q] <= irqb_s;
        power_in_vector[sel_q] <= pwr_s;
        sel_q <= sel_q + SEL_STEP;
      end
    end
  end

  assign mux_select = sel_q;
  // Bus reset is the strap code with the decoder enabled
  assign ack_decoder_enable = ~scan_en_q | dma_ack_active
    | (bus_reset_req_q & (sel_q == SEL_STRAP));

  // Hold stretch after each refresh; runs even with the clock stopped
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stretch_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (refresh_done)
      begin
        stretch_cnt_q <= STRETCH_CW'(stretch_eff)
          * STRETCH_CW'(CYCLES_PER_US);
      end
      else if (stretch_cnt_q != '0)
      begin
        stretch_cnt_q <= stretch_cnt_q - STRETCH_CW'(1);
      end
    end
  end

  assign hold_request = refresh_busy | (stretch_cnt_q != '0);
  assign refresh_out = full_off ? (cbr_refresh_en & tick_s)
    : refresh_req;

  // Clock stop state
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_state_q <= CLK_RUN;
    end
    else if (clk_en && !full_off)
    begin
      case (clk_state_q)
        CLK_RUN:
        begin
          if ((ccr_q[CCR_HALT_HOLD_STOP_BIT] && halt_m && hold_m)
            || (ccr_q[CCR_HOLD_STOP_BIT] && hold_m))
          begin
            clk_state_q <= CLK_STOPPED;
          end
        end
        CLK_STOPPED:
        begin
          if (wake_evt)
          begin
            clk_state_q <= CLK_RUN;
          end
        end
        default:
        begin
          clk_state_q <= CLK_RUN;
        end
      endcase
    end
  end

  // Divisor shape: period and high time in ref_clk cycles
  always_comb
  begin
    div_period = 4'h2;
    div_high = 4'h1;
    case (div_sel)
      DIV_BY2:
      begin
        div_period = 4'h4;
        div_high = 4'h2;
      end
      DIV_BY4_25:
      begin
        div_period = 4'h8;
        div_high = 4'h2;
      end
      DIV_BY4_75:
      begin
        div_period = 4'h8;
        div_high = 4'h6;
      end
      DIV_BY8_12:
      begin
        div_period = 4'hf;
        div_high = 4'h2;
      end
      DIV_BY8_88:
      begin
        div_period = 4'hf;
        div_high = 4'hd;
      end
      default:
      begin
        div_period = 4'h2;
        div_high = 4'h1;
      end
    endcase
  end

  // Stopped clock parks low, the second processor phase
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt_q <= '0;
      cpu_clk_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (clk_state_q == CLK_STOPPED || full_off)
      begin
        div_cnt_q <= '0;
        cpu_clk_q <= 1'b0;
      end
      else
      begin
        div_cnt_q <= (div_cnt_q + 4'h1 >= div_period) ? 4'h0
          : div_cnt_q + 4'h1;
        cpu_clk_q <= (div_cnt_q < div_high);
      end
    end
  end

  assign processor_clock = cpu_clk_q;
  assign processor_clock_oe_n = clk_dir_in_q || cpu_outputs_oe_n
    || (div_sel == DIV_INPUT);

  // Power-down request armed only by a rising write of the bit
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pd_armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_pwr && io_wdata[PWR_CPU_PD_BIT] && !pwr_q[PWR_CPU_PD_BIT])
      begin
        pd_armed_q <= 1'b1;
      end
      else if (pd_state_q == PD_CPU_OFF)
      begin
        pd_armed_q <= 1'b0;
      end
    end
  end

  // Power-down sequencer
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pd_state_q <= PD_IDLE;
      wake_full_q <= 1'b0;
      rst_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      case (pd_state_q)
        PD_IDLE:
        begin
          if (pwr_q[PWR_FULL_PD_BIT] && halt_m)
          begin
            pd_state_q <= PD_FULL_OFF;
          end
          else if (pd_armed_q && halt_m)
          begin
            pd_state_q <= PD_CPU_OFF;
          end
        end
        PD_CPU_OFF:
        begin
          if (wake_evt || dma_ack_active || request_vector != '0)
          begin
            pd_state_q <= PD_WAKE;
            wake_full_q <= 1'b0;
          end
        end
        PD_FULL_OFF:
        begin
          if (power_ctrl_irq)
          begin
            pd_state_q <= PD_WAKE;
            wake_full_q <= 1'b1;
          end
        end
        PD_WAKE:
        begin
          // Power good is only seen once the scan passes its code
          if (power_good)
          begin
            pd_state_q <= PD_RESET;
            rst_cnt_q <= '0;
          end
        end
        PD_RESET:
        begin
          if (rst_cnt_q == CNT_W'(CPU_RESET_CYCLES))
          begin
            pd_state_q <= PD_IDLE;
          end
          else
          begin
            rst_cnt_q <= rst_cnt_q + CNT_W'(1);
          end
        end
        default:
        begin
          pd_state_q <= PD_IDLE;
        end
      endcase
    end
  end

  // Bus reset only on a wake from full power-down
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_reset_req_q <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_reset_req_q <= (pd_state_q == PD_WAKE) && wake_full_q;
    end
  end

  assign power_ctrl_out5 = (pd_state_q == PD_CPU_OFF);
  assign power_ctrl_out7 = full_off;
  assign cpu_outputs_oe_n = (pd_state_q == PD_CPU_OFF)
    || full_off || (pd_state_q == PD_WAKE);
  assign cpu_inputs_masked = cpu_outputs_oe_n;
  assign cpu_pullup_en = ~cpu_outputs_oe_n;
  assign cpu_reset_out = (pd_state_q == PD_RESET)
    || ((pd_state_q == PD_WAKE) && wake_full_q);
endmodule : cpu_clock_power_mux_ctrl

// [sim/cpu_clock_power_mux_ctrl_chk.sv]
module cpu_clock_power_mux_ctrl_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  // Processor and DMA status
  input wire logic cpu_halt,
  input wire logic cpu_hold,
  input wire logic irq_unmasked,
  input wire logic nmi,
  input wire logic power_ctrl_irq,
  input wire logic dma_ack_active,
  input wire logic [2:0] dma_channel,
  // Watched outputs
  input wire logic [2:0] mux_select,
  input wire logic ack_decoder_enable,
  input wire logic processor_clock,
  input wire logic cpu_outputs_oe_n,
  input wire logic cpu_inputs_masked,
  input wire logic cpu_pullup_en,
  input wire logic power_ctrl_out5,
  input wire logic power_ctrl_out7,
  input wire logic cpu_reset_out
);
  import cpu_clock_power_pkg::*;
  logic [3:0] stretch_q;
  logic [1:0] stop_q;
  logic [7:0] ccr_low;
  assign ccr_low = {stretch_q, 2'b00, stop_q};
  // Mirror assumes wake is only raised while the clock is stopped
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stretch_q <= 4'h0;
      stop_q <= 2'h0;
    end
    else if (io_wr && io_addr == ADDR_CPU_CLOCK_CONTROL)
    begin
      stretch_q <= io_wdata[7:4];
      stop_q <= io_wdata[1:0];
    end
    else if (irq_unmasked || nmi)
    begin
      stop_q[0] <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  property p_strap_select;
    $rose(arst_n) |-> (mux_select == SEL_STRAP && ack_decoder_enable) [*8];
  endproperty
  a_strap_select: assert property (p_strap_select)
    else $error("select left strap code too early");
  property p_dma_stable;
    (dma_ack_active && $stable(dma_channel)) [*3] |-> $stable(mux_select);
  endproperty
  a_dma_stable: assert property (p_dma_stable)
    else $error("select moved during DMA");
  property p_scan_step;
    !dma_ack_active && !$past(dma_ack_active) && !$past(dma_ack_active, 2)
      && mux_select != $past(mux_select)
      |-> mux_select == 3'($past(mux_select) + SEL_STEP);
  endproperty
  a_scan_step: assert property (p_scan_step)
    else $error("scan skipped a code");
  property p_hold_stop;
    stop_q[0] && cpu_hold && !cpu_inputs_masked && !irq_unmasked && !nmi
      |=> ##1 !processor_clock;
  endproperty
  a_hold_stop: assert property (p_hold_stop)
    else $error("clock not stopped at hold");
  property p_halt_hold_stop;
    stop_q[1] && cpu_halt && cpu_hold && !cpu_inputs_masked
      && !irq_unmasked && !nmi |=> ##1 !processor_clock;
  endproperty
  a_halt_hold_stop: assert property (p_halt_hold_stop)
    else $error("clock not stopped at halt and hold");
  property p_read_ccr;
    io_rd && io_addr == ADDR_CPU_CLOCK_CONTROL
      |=> io_rdata[7:0] == $past(ccr_low);
  endproperty
  a_read_ccr: assert property (p_read_ccr)
    else $error("clock control low byte wrong");
  property p_pd_outputs;
    power_ctrl_out5 |-> cpu_outputs_oe_n && cpu_inputs_masked
      && !cpu_pullup_en;
  endproperty
  a_pd_outputs: assert property (p_pd_outputs)
    else $error("processor side active in power-down");
  property p_full_wake;
    power_ctrl_out7 && power_ctrl_irq
      |-> ##[1:3] (!power_ctrl_out7 && cpu_reset_out);
  endproperty
  a_full_wake: assert property (p_full_wake)
    else $error("no reset on full power-down wake");
  c_out5: cover property (power_ctrl_out5);
  c_out7: cover property (power_ctrl_out7);
  c_dma: cover property (dma_ack_active [*3]);
endmodule : cpu_clock_power_mux_ctrl_chk

bind cpu_clock_power_mux_ctrl cpu_clock_power_mux_ctrl_chk chk (.*);

// [sim/mux_model.sv]
module mux_model (
  // Select from the device
  input wire logic [2:0] mux_select,
  // Level seen at each select code
  input wire logic [7:0] req_pat,
  input wire logic [7:0] irqa_pat,
  input wire logic [7:0] irqb_pat,
  input wire logic [7:0] pwr_pat,
  // Muxed pins
  output logic bus_clock_double,
  output logic muxed_request_in,
  output logic muxed_irq_in_a,
  output logic muxed_irq_in_b,
  output logic muxed_power_in
);
  timeunit 1ns;
  timeprecision 10ps;
  // Free running, so eight codes take 500 ns
  initial
  begin
    bus_clock_double = 1'b0;
    forever #31.25 bus_clock_double = ~bus_clock_double;
  end
  // The mux always drives its selected line
  assign muxed_request_in = req_pat[mux_select];
  assign muxed_irq_in_a = irqa_pat[mux_select];
  assign muxed_irq_in_b = irqb_pat[mux_select];
  assign muxed_power_in = pwr_pat[mux_select];
endmodule : mux_model

// [sim/cpu_clock_power_mux_ctrl_tb.sv]
module cpu_clock_power_mux_ctrl_tb;
  timeunit 1ns;
  timeprecision 10ps;
  import cpu_clock_power_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [15:0] io_wdata = 16'h0000;
  logic cpu_halt = 1'b0;
  logic cpu_hold = 1'b0;
  logic irq_unmasked = 1'b0;
  logic nmi = 1'b0;
  logic power_ctrl_irq = 1'b0;
  logic refresh_busy = 1'b0;
  logic refresh_done = 1'b0;
  logic refresh_req = 1'b0;
  logic cbr_refresh_en = 1'b1;
  logic dma_ack_active = 1'b0;
  logic [2:0] dma_channel = 3'h0;
  logic sleep_refresh_tick = 1'b0;
  logic [7:0] req_pat = 8'h00;
  logic [7:0] irqa_pat = 8'h00;
  logic [7:0] irqb_pat = 8'h00;
  logic [7:0] pwr_pat = 8'h02;
  logic bus_clock_double, muxed_request_in, muxed_irq_in_a;
  logic muxed_irq_in_b, muxed_power_in, ack_decoder_enable;
  logic [15:0] io_rdata;
  logic [2:0] mux_select;
  logic [7:0] request_vector, irq_a_vector, irq_b_vector, power_in_vector;
  logic boot_rom_width, speed_switch_input, processor_clock;
  logic processor_clock_oe_n, hold_request, cpu_reset_out;
  logic cpu_outputs_oe_n, cpu_inputs_masked, cpu_pullup_en;
  logic power_ctrl_out5, power_ctrl_out7, refresh_out;
  int num_errors = 0;
  int check_count = 0;
  mux_model far_end (.*);
  cpu_clock_power_mux_ctrl DUT (.*);
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input string n, input logic [15:0] a,
    input logic [15:0] e);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, io_rdata, e);
  endtask : rdchk
  task automatic hicount(input int sel, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      if ((sel == 0 ? hold_request : cpu_reset_out) === 1'b1)
        c++;
    end
  endtask : hicount
  task automatic toggles(output int c);
    logic p;
    c = 0;
    @(negedge ref_clk);
    p = processor_clock;
    repeat (16)
    begin
      @(negedge ref_clk);
      if (processor_clock !== p)
        c++;
      p = processor_clock;
    end
  endtask : toggles
  task automatic stretch_len(output int c);
    @(posedge ref_clk);
    refresh_done <= 1'b1;
    @(posedge ref_clk);
    refresh_done <= 1'b0;
    hicount(0, 1700, c);
  endtask : stretch_len
  task automatic wait_pwr(input logic [7:0] e);
    int i;
    @(posedge ref_clk);
    pwr_pat <= e;
    for (i = 0; i < 300 && power_in_vector !== e; i++)
      cyc(1);
    if (i == 300)
    begin
      chk("scan wait", power_in_vector, e);
      end_sim();
    end
    cyc(60);
  endtask : wait_pwr
  task automatic do_reset(input logic rq, input logic ra);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    req_pat <= {3'h0, rq, 4'h0};
    irqa_pat <= {3'h0, ra, 4'h0};
    cyc(4);
    arst_n <= 1'b1;
    cyc(30);
  endtask : do_reset
  initial
  begin
    #800000;
    num_errors++;
    end_sim();
  end
  initial
  begin
    int c;
    do_reset(1'b0, 1'b1);
    rdchk("ccr", ADDR_CPU_CLOCK_CONTROL, CCR_RESET);
    rdchk("pwr", ADDR_COPROC_BUS_POWER, PWR_RESET);
    rdchk("unmapped", 16'h1074, 16'h0000);
    chk("rom", boot_rom_width, 1'b1);
    chk("clk oe", processor_clock_oe_n, 1'b0);
    $display("test reset done");
    req_pat <= 8'ha5;
    irqa_pat <= 8'h3c;
    irqb_pat <= 8'h96;
    wait_pwr(8'h02);
    chk("req", request_vector, 8'ha5);
    chk("irq a", irq_a_vector, 8'h3c);
    chk("irq b", irq_b_vector, 8'h96);
    chk("speed", speed_switch_input, 1'b0);
    dma_channel <= 3'h5;
    dma_ack_active <= 1'b1;
    cyc(3);
    chk("dma sel", mux_select, 3'h5);
    chk("dack en", ack_decoder_enable, 1'b1);
    cyc(10);
    chk("dma hold", mux_select, 3'h5);
    dma_ack_active <= 1'b0;
    req_pat <= 8'h00;
    $display("test scan done");
    wr(ADDR_CPU_CLOCK_CONTROL, 16'h1020);
    stretch_len(c);
    chk("stretch", 16'(c), 16'(2 * CYCLES_PER_US));
    wait_pwr(8'h03);
    chk("speed", speed_switch_input, 1'b1);
    wr(ADDR_CPU_CLOCK_CONTROL, 16'h10f0);
    stretch_len(c);
    chk("forced", 16'(c), 16'h0000);
    wait_pwr(8'h02);
    stretch_len(c);
    chk("restored", 16'(c), 16'(15 * CYCLES_PER_US));
    $display("test stretch done");
    wr(ADDR_CPU_CLOCK_CONTROL, 16'h100d);
    rdchk("reserved", ADDR_CPU_CLOCK_CONTROL, 16'h1001);
    toggles(c);
    chk("run", 16'(c), 16'h0010);
    @(posedge ref_clk);
    cpu_hold <= 1'b1;
    refresh_req <= 1'b1;
    cyc(2);
    toggles(c);
    chk("hold stop", 16'(c), 16'h0000);
    chk("phase", processor_clock, 1'b0);
    chk("refresh", refresh_out, 1'b1);
    @(posedge ref_clk);
    refresh_req <= 1'b0;
    irq_unmasked <= 1'b1;
    cyc(2);
    irq_unmasked <= 1'b0;
    toggles(c);
    chk("restart", 16'(c), 16'h0010);
    rdchk("sch clr", ADDR_CPU_CLOCK_CONTROL, 16'h1000);
    @(posedge ref_clk);
    cpu_hold <= 1'b0;
    wr(ADDR_CPU_CLOCK_CONTROL, 16'h1002);
    @(posedge ref_clk);
    cpu_halt <= 1'b1;
    toggles(c);
    chk("halt only", 16'(c), 16'h0010);
    @(posedge ref_clk);
    cpu_hold <= 1'b1;
    cyc(2);
    toggles(c);
    chk("hh stop", 16'(c), 16'h0000);
    @(posedge ref_clk);
    nmi <= 1'b1;
    @(posedge ref_clk);
    nmi <= 1'b0;
    cyc(2);
    toggles(c);
    chk("restop", 16'(c), 16'h0000);
    rdchk("halt_hold_clock_stop kept", ADDR_CPU_CLOCK_CONTROL, 16'h1002);
    @(posedge ref_clk);
    cpu_halt <= 1'b0;
    cpu_hold <= 1'b0;
    wr(ADDR_CPU_CLOCK_CONTROL, 16'h1000);
    $display("test clock stop done");
    wait_pwr(8'h00);
    wr(ADDR_COPROC_BUS_POWER, 16'h40c2);
    @(posedge ref_clk);
    cpu_halt <= 1'b1;
    cyc(3);
    cpu_halt <= 1'b0;
    @(negedge ref_clk);
    chk("out5", power_ctrl_out5, 1'b1);
    chk("cpu oe", cpu_outputs_oe_n, 1'b1);
    chk("pullup", cpu_pullup_en, 1'b0);
    @(posedge ref_clk);
    irq_unmasked <= 1'b1;
    cyc(3);
    irq_unmasked <= 1'b0;
    cyc(20);
    @(negedge ref_clk);
    chk("out5 wake", power_ctrl_out5, 1'b0);
    chk("still off", cpu_outputs_oe_n, 1'b1);
    @(posedge ref_clk);
    pwr_pat <= 8'h02;
    hicount(1, 400, c);
    chk("reset len", 16'(c), 16'(CPU_RESET_CYCLES + 1));
    chk("cpu on", cpu_outputs_oe_n, 1'b0);
    wr(ADDR_COPROC_BUS_POWER, PWR_RESET);
    $display("test power-down done");
    wr(ADDR_COPROC_BUS_POWER, 16'h20c2);
    @(posedge ref_clk);
    cpu_halt <= 1'b1;
    cyc(3);
    cpu_halt <= 1'b0;
    sleep_refresh_tick <= 1'b1;
    cyc(6);
    @(negedge ref_clk);
    chk("out7", power_ctrl_out7, 1'b1);
    chk("full oe", cpu_outputs_oe_n, 1'b1);
    chk("tick hi", refresh_out, 1'b1);
    @(posedge ref_clk);
    sleep_refresh_tick <= 1'b0;
    cyc(6);
    @(negedge ref_clk);
    chk("tick lo", refresh_out, 1'b0);
    @(posedge ref_clk);
    power_ctrl_irq <= 1'b1;
    @(posedge ref_clk);
    power_ctrl_irq <= 1'b0;
    @(negedge ref_clk);
    chk("out7 wake", power_ctrl_out7, 1'b0);
    chk("wake rst", cpu_reset_out, 1'b1);
    hicount(1, 400, c);
    chk("full rst", 16'(c), 16'(CPU_RESET_CYCLES + 1));
    chk("rst end", cpu_reset_out, 1'b0);
    chk("unmask", cpu_inputs_masked, 1'b0);
    rdchk("fpd kept", ADDR_COPROC_BUS_POWER, 16'h20c2);
    wr(ADDR_COPROC_BUS_POWER, PWR_RESET);
    $display("test full power-down done");
    do_reset(1'b1, 1'b0);
    rdchk("ccr in", ADDR_CPU_CLOCK_CONTROL, 16'h0000);
    chk("rom", boot_rom_width, 1'b0);
    chk("clk in", processor_clock_oe_n, 1'b1);
    $display("test strap done");
    end_sim();
  end
endmodule : cpu_clock_power_mux_ctrl_tb
